// >>> src/timer_ch1_defines.vh
// register map, field layout and reset values of the channel 1 capture/configuration block
// included by the channel top and its filter; definitions only
`ifndef TIMER_CH1_DEFINES_VH
`define TIMER_CH1_DEFINES_VH

`define OFS_MODE        6'h18
`define OFS_ENABLE      6'h20
`define OFS_VALUE       6'h34
`define OFS_STATUS      6'h38
`define OFS_MASK        6'h3c

`define DIR_LSB         0
`define DIR_MSB         1
`define PSC_LSB         2
`define PSC_MSB         3
`define FLT_LSB         4
`define FLT_MSB         7

`define EN_BIT          0
`define POL_BIT         1
`define NEN_BIT         2
`define NPOL_BIT        3

`define ST_CAPTURE      0
`define ST_OVERCAPTURE  1
`define ST_WIDTH        2

`define DIR_OUTPUT      2'h0
`define DIR_TI1         2'h1
`define DIR_TI2         2'h2
`define DIR_TRC         2'h3

`define EDGE_RISE       2'h0
`define EDGE_FALL       2'h1
`define EDGE_BOTH       2'h3

`define FLT_OFF         4'h0
`define PROT_MIN_LOCK   2'h2

`define RESET_MODE      8'h00
`define RESET_ENABLE    4'h0
`define RESET_VALUE     16'h0000
`define RESET_ST        2'h0
`define RESET_DIR       2'h0
`define RESET_PSC       2'h0
`define RESET_FLT       4'h0
`define RESET_BIT       1'b0

`define HTRANS_NONSEQ_BIT 1

`endif

// >>> src/sample_filter.v
// digital glitch filter: the output follows the input only after a run of agreeing samples
// assumes sample_tick is a one-cycle enable and need_count is at least 1
`default_nettype none
`include "timer_ch1_defines.vh"

module sample_filter #(
	parameter CW = 4
) (
	input  wire          hclk,
	input  wire          hresetn,
	input  wire          sample_tick,
	input  wire          din,
	input  wire [CW-1:0] need_count,
	output reg           dout
);

	reg [CW-1:0] run;

	// a sample equal to the current output restarts the run, so only an unbroken run flips it
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run  <= {CW{1'b0}};
			dout <= 1'b0;
		end else if (sample_tick) begin
			if (din == dout) begin
				run <= {CW{1'b0}};
			end else if (run + {{(CW-1){1'b0}}, 1'b1} >= need_count) begin
				run  <= {CW{1'b0}};
				dout <= din; // RULE7
			end else begin
				run <= run + {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule
`default_nettype wire

// >>> src/timer_channel1_capture_config.v
// channel 1 configuration and input capture of a general timer, with an AHB-Lite register slave
// assumes counter_value, the timer inputs and the dead-time tick are synchronous to hclk
//
// Contract
// RULE1: direction code 00 makes channel 1 an output-compare channel.
// RULE2: codes 01, 10, 11 capture from input one, input two, internal trigger.
// RULE3: direction field writes take effect only while the channel enable is clear.
// RULE4: prescaler codes 00..11 capture once per 1, 2, 4 or 8 events.
// RULE5: filter code 0000 samples unfiltered at the dead-time sample clock.
// RULE6: nonzero filter codes sample at timer clock divided by the tabulated divider.
// RULE7: a transition passes only after N consecutive agreeing samples.
// RULE8: in output mode the enable bit gates the main output.
// RULE9: in input mode the enable bit gates capture of the counter value.
// RULE10: main polarity 0 gives active-high output, 1 active-low.
// RULE11: input polarity pair 00 captures rising edges, 01 falling edges inverted.
// RULE12: pair 11 captures both edges; pair 10 is reserved, software avoids it.
// RULE13: complement enable bit gates the complementary output.
// RULE14: complement polarity 0 active high, 1 active low.
// RULE15: protection level 2 or 3 blocks writes to complement polarity.
// RULE16: in input mode the value register holds the last captured counter.
// RULE17: reserved bits read zero and ignore writes.
`default_nettype none
`include "timer_ch1_defines.vh"

module timer_channel1_capture_config #(
	parameter CNT_W = 16
) (
	input  wire             hclk,
	input  wire             hresetn,
	input  wire             hsel,
	input  wire [31:0]      haddr,
	input  wire [1:0]       htrans,
	input  wire             hwrite,
	input  wire [2:0]       hsize,
	input  wire [31:0]      hwdata,
	input  wire             hready,
	output reg              hreadyout,
	output reg              hresp,
	output reg  [31:0]      hrdata,
	input  wire             timer_input_one,
	input  wire             timer_input_two,
	input  wire             internal_trigger_selection,
	input  wire             dead_time_sample_clock,
	input  wire [CNT_W-1:0] counter_value,
	input  wire             compare_reference,
	input  wire [1:0]       protect_level,
	output reg              ch1_main_output,
	output reg              ch1_complement_output,
	output reg              capture_strobe,
	output reg  [CNT_W-1:0] ch1_value_register,
	output reg              irq
);

	// configuration registers
	reg [1:0]           ch1_direction_select;
	reg [1:0]           ch1_capture_event_divider;
	reg [3:0]           ch1_input_filter_setting;
	reg                 ch1_channel_enable;
	reg                 ch1_main_polarity;
	reg                 ch1_complement_enable;
	reg                 ch1_complement_polarity;
	reg [`ST_WIDTH-1:0] status;
	reg [`ST_WIDTH-1:0] mask;

	// bus pipeline
	reg                 wr_pend;
	reg                 rd_pend;
	reg [5:0]           dp_addr;

	// filter timing and edge detection
	reg [4:0]           div_cnt;
	reg [4:0]           div_mask;
	reg [3:0]           need_n;
	reg                 trc_last;
	reg                 src_last;
	reg [2:0]           event_cnt;
	reg [2:0]           event_limit;

	wire                filtered_input_one_edge;
	wire                filtered_input_two_edge;
	wire                sample_tick;
	wire                input_mode;
	wire                addr_take;
	wire                bus_write;
	wire [1:0]          edge_pair;
	wire                ch1_capture_source;
	wire                rise;
	wire                fall;
	wire                trc_rise;
	wire                qualified_event;
	wire                capture_now;
	wire [`ST_WIDTH-1:0] next_status;
	wire [`ST_WIDTH-1:0] st_set;
	wire [`ST_WIDTH-1:0] st_clr;

	assign input_mode = (ch1_direction_select != `DIR_OUTPUT); // RULE1
	assign addr_take  = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
	assign bus_write  = wr_pend;

	// AHB-Lite slave: writes finish with no wait, reads take one wait state so that a
	// read right behind a write returns the freshly written value
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			dp_addr   <= 6'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end else begin
			if (rd_pend) begin
				rd_pend   <= 1'b0;
				hreadyout <= 1'b1;
				case (dp_addr)
				`OFS_MODE:   hrdata <= {24'h000000, ch1_input_filter_setting,
					ch1_capture_event_divider, ch1_direction_select}; // RULE17
				`OFS_ENABLE: hrdata <= {28'h0000000, ch1_complement_polarity, ch1_complement_enable,
					ch1_main_polarity, ch1_channel_enable}; // RULE17
				`OFS_VALUE:  hrdata <= {{(32-CNT_W){1'b0}}, ch1_value_register};
				`OFS_STATUS: hrdata <= {{(32-`ST_WIDTH){1'b0}}, status};
				`OFS_MASK:   hrdata <= {{(32-`ST_WIDTH){1'b0}}, mask};
				default:     hrdata <= 32'h00000000;
				endcase
			end else if (addr_take) begin
				dp_addr   <= haddr[5:0];
				wr_pend   <= hwrite & (haddr[31:6] == 26'h0000000);
				rd_pend   <= ~hwrite;
				hreadyout <= hwrite;
			end else begin
				wr_pend <= 1'b0;
			end
			if (!addr_take && !rd_pend) begin
				wr_pend <= 1'b0;
			end
		end
	end

	// configuration writes, with their guards
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ch1_direction_select      <= `RESET_DIR;
			ch1_capture_event_divider <= `RESET_PSC;
			ch1_input_filter_setting  <= `RESET_FLT;
			ch1_channel_enable        <= `RESET_BIT;
			ch1_main_polarity         <= `RESET_BIT;
			ch1_complement_enable     <= `RESET_BIT;
			ch1_complement_polarity   <= `RESET_BIT;
			mask                      <= `RESET_ST;
		end else if (bus_write) begin
			case (dp_addr)
			`OFS_MODE: begin
				if (!ch1_channel_enable) begin
					ch1_direction_select <= hwdata[`DIR_MSB:`DIR_LSB]; // RULE3
				end
				ch1_capture_event_divider <= hwdata[`PSC_MSB:`PSC_LSB];
				ch1_input_filter_setting  <= hwdata[`FLT_MSB:`FLT_LSB];
			end
			`OFS_ENABLE: begin
				ch1_channel_enable    <= hwdata[`EN_BIT];
				ch1_main_polarity     <= hwdata[`POL_BIT];
				ch1_complement_enable <= hwdata[`NEN_BIT];
				if (protect_level < `PROT_MIN_LOCK) begin
					ch1_complement_polarity <= hwdata[`NPOL_BIT]; // RULE15
				end
			end
			`OFS_MASK: mask <= hwdata[`ST_WIDTH-1:0];
			default: ;
			endcase
		end
	end

	// filter divider and run length per filter code
	always @* begin
		case (ch1_input_filter_setting)
		4'h1: begin div_mask = 5'h00; need_n = 4'h2; end
		4'h2: begin div_mask = 5'h00; need_n = 4'h4; end
		4'h3: begin div_mask = 5'h00; need_n = 4'h8; end
		4'h4: begin div_mask = 5'h01; need_n = 4'h6; end
		4'h5: begin div_mask = 5'h01; need_n = 4'h8; end
		4'h6: begin div_mask = 5'h03; need_n = 4'h6; end
		4'h7: begin div_mask = 5'h03; need_n = 4'h8; end
		4'h8: begin div_mask = 5'h07; need_n = 4'h6; end
		4'h9: begin div_mask = 5'h07; need_n = 4'h8; end
		4'ha: begin div_mask = 5'h0f; need_n = 4'h5; end
		4'hb: begin div_mask = 5'h0f; need_n = 4'h6; end
		4'hc: begin div_mask = 5'h0f; need_n = 4'h8; end
		4'hd: begin div_mask = 5'h1f; need_n = 4'h5; end
		4'he: begin div_mask = 5'h1f; need_n = 4'h6; end
		4'hf: begin div_mask = 5'h1f; need_n = 4'h8; end
		default: begin div_mask = 5'h00; need_n = 4'h1; end
		endcase
	end

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt <= 5'h00;
		end else begin
			div_cnt <= div_cnt + 5'h01;
		end
	end

	// a free-running counter gives every power-of-two divider without reloading on code change
	assign sample_tick = (ch1_input_filter_setting == `FLT_OFF) ? dead_time_sample_clock // RULE5
		: &(div_cnt | ~div_mask); // RULE6

	sample_filter #(
		.CW(4)
	) filter_one (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.sample_tick (sample_tick),
		.din         (timer_input_one),
		.need_count  (need_n),
		.dout        (filtered_input_one_edge)
	);

	sample_filter #(
		.CW(4)
	) filter_two (
		.hclk        (hclk),
		.hresetn     (hresetn),
		.sample_tick (sample_tick),
		.din         (timer_input_two),
		.need_count  (need_n),
		.dout        (filtered_input_two_edge)
	);

	// source select and edge sense
	assign ch1_capture_source = (ch1_direction_select == `DIR_TI2) ? filtered_input_two_edge
		: filtered_input_one_edge; // RULE2
	assign edge_pair = {ch1_complement_polarity, ch1_main_polarity};
	assign rise      = ch1_capture_source & ~src_last;
	assign fall      = ~ch1_capture_source & src_last;
	assign trc_rise  = internal_trigger_selection & ~trc_last;

	// reserved pair 10 falls back to rising edges
	assign qualified_event = (ch1_direction_select == `DIR_TRC) ? trc_rise // RULE2
		: (edge_pair == `EDGE_FALL) ? fall // RULE11
		: (edge_pair == `EDGE_BOTH) ? (rise | fall) // RULE12
		: rise; // RULE11

	always @* begin
		case (ch1_capture_event_divider)
		2'h1:    event_limit = 3'h1;
		2'h2:    event_limit = 3'h3;
		2'h3:    event_limit = 3'h7;
		default: event_limit = 3'h0;
		endcase
	end

	assign capture_now = input_mode & ch1_channel_enable & qualified_event
		& (event_cnt == event_limit); // RULE4 RULE9

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_last  <= 1'b0;
			trc_last  <= 1'b0;
			event_cnt <= 3'h0;
		end else begin
			src_last <= ch1_capture_source;
			trc_last <= internal_trigger_selection;
			// the prescaler restarts whenever capture is off so the first event after enable counts as one
			if (!(input_mode && ch1_channel_enable)) begin
				event_cnt <= 3'h0;
			end else if (qualified_event) begin
				event_cnt <= capture_now ? 3'h0 : event_cnt + 3'h1; // RULE4
			end
		end
	end

	// capture register and event flags; a hardware set beats a same-cycle software clear
	assign st_set = {capture_now & status[`ST_CAPTURE], capture_now};
	assign st_clr = (bus_write && dp_addr == `OFS_STATUS) ? hwdata[`ST_WIDTH-1:0] : `RESET_ST;
	assign next_status = (status & ~st_clr) | st_set;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ch1_value_register <= `RESET_VALUE;
			capture_strobe     <= 1'b0;
			status             <= `RESET_ST;
			irq                <= 1'b0;
		end else begin
			capture_strobe <= capture_now;
			status         <= next_status;
			irq            <= |(next_status & mask);
			if (capture_now) begin
				ch1_value_register <= counter_value; // RULE16 RULE9
			end else if (bus_write && dp_addr == `OFS_VALUE && !input_mode) begin
				ch1_value_register <= hwdata[CNT_W-1:0];
			end
		end
	end

	// output stage; a disabled output rests at 0 whatever its polarity
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ch1_main_output       <= 1'b0;
			ch1_complement_output <= 1'b0;
		end else begin
			ch1_main_output <= ~input_mode & ch1_channel_enable
				& (compare_reference ^ ch1_main_polarity); // RULE1 RULE8 RULE10
			ch1_complement_output <= ~input_mode & ch1_complement_enable
				& (~compare_reference ^ ch1_complement_polarity); // RULE13 RULE14
		end
	end

endmodule
`default_nettype wire

// >>> verif/pin_source.sv
// pin-side model of channel 1: pulses one of its three capture sources
// assumes go is a one-cycle request sampled on the rising edge of hclk
`default_nettype none
module pin_source (
	input  wire logic       hclk,
	input  wire logic       go,
	input  wire logic [1:0] sel,
	input  wire logic [4:0] len,
	output wire logic       timer_input_one,
	output wire logic       timer_input_two,
	output wire logic       internal_trigger_selection
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] left = 5'h00;
	logic [1:0] line = 2'h0;
	always @(posedge hclk) begin
		if (go) begin
			left <= len;
			line <= sel;
		end else if (left != 5'h00) begin
			left <= left - 5'h01;
		end
	end
	// lines rest low between pulses, like a pin with a pull-down
	assign timer_input_one = (left != 5'h00) && (line == 2'h0);
	assign timer_input_two = (left != 5'h00) && (line == 2'h1);
	assign internal_trigger_selection = (left != 5'h00) && (line == 2'h2);
endmodule
`default_nettype wire

// >>> verif/timer_ch1_sva.sv
// assertion checker for channel 1, watching the top module's ports only
// mirrors the enable and direction fields from writes seen on the bus
`default_nettype none
`include "timer_ch1_defines.vh"
module timer_ch1_sva #(
	parameter CNT_W = 16
) (
	input wire logic             hclk,
	input wire logic             hresetn,
	input wire logic             hsel,
	input wire logic [31:0]      haddr,
	input wire logic [1:0]       htrans,
	input wire logic             hwrite,
	input wire logic [31:0]      hwdata,
	input wire logic             hready,
	input wire logic             hreadyout,
	input wire logic             hresp,
	input wire logic             compare_reference,
	input wire logic [1:0]       protect_level,
	input wire logic             ch1_main_output,
	input wire logic             ch1_complement_output,
	input wire logic             capture_strobe,
	input wire logic [CNT_W-1:0] ch1_value_register,
	input wire logic             irq
);
	logic [5:0] wa;
	logic       wv;
	logic [3:0] en;
	logic [1:0] dir;
	wire logic  vw = wv && (wa == `OFS_VALUE);
	wire logic  mw = wv && (wa == `OFS_MASK);
	wire logic  cap_ok = en[0] && (dir != `DIR_OUTPUT);
	wire logic  m_exp = (dir == `DIR_OUTPUT) && en[0] && (compare_reference ^ en[1]);
	wire logic  c_exp = (dir == `DIR_OUTPUT) && en[2] && (!compare_reference ^ en[3]);
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wa <= 6'h00;
			wv <= 1'b0;
			en <= 4'h0;
			dir <= 2'h0;
		end else begin
			wa <= haddr[5:0];
			wv <= hsel && hready && htrans[1] && hwrite && (haddr[31:6] == 26'h0);
			if (wv && wa == `OFS_ENABLE)
				en <= {(protect_level >= `PROT_MIN_LOCK) ? en[3] : hwdata[3], hwdata[2:0]};
			if (wv && wa == `OFS_MODE && !en[0])
				dir <= hwdata[1:0];
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	AST_MAIN_OUT: assert property (ch1_main_output == $past(m_exp))
		else $error("main output does not follow enable, polarity and reference");
	AST_COMP_OUT: assert property (ch1_complement_output == $past(c_exp))
		else $error("complement output does not follow its enable and polarity");
	AST_NO_CAPTURE: assert property (!cap_ok && !$past(cap_ok) |-> !capture_strobe)
		else $error("capture while disabled or in output mode");
	AST_VALUE_HOLD: assert property (!capture_strobe && !$past(vw) |-> $stable(ch1_value_register))
		else $error("value register changed without capture or write");
	AST_HRESP_OKAY: assert property (hresp == 1'b0)
		else $error("error response on the bus");
	AST_READ_WAIT: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read does not take exactly one wait state");
	AST_WRITE_NOWAIT: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
		else $error("write inserted a wait state");
	AST_IRQ_CAUSE: assert property ($rose(irq) |-> capture_strobe || $past(mw) || $past(mw, 2))
		else $error("interrupt rose without capture or mask write");
endmodule
bind timer_channel1_capture_config timer_ch1_sva #(.CNT_W(CNT_W)) u_sva (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .compare_reference, .protect_level,
	.ch1_main_output, .ch1_complement_output, .capture_strobe, .ch1_value_register, .irq);
`default_nettype wire

// >>> verif/timer_channel1_capture_config_tb_top.sv
// self-checking bench for the channel 1 capture and configuration block
// assumes one 10 MHz clock; this module is the only bus master
`default_nettype none
module timer_channel1_capture_config_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic        dts = 1'b1;
	logic [15:0] counter_value = 16'h0;
	logic        compare_reference = 1'b0;
	logic [1:0]  protect_level = 2'h0;
	logic        go = 1'b0;
	logic [1:0]  sel = 2'h0;
	logic [4:0]  plen = 5'h01;
	int          error_cnt = 0;
	int          n_checks = 0;
	int          scnt = 0;
	wire logic   hreadyout, hresp, ch1_main_output, ch1_complement_output, capture_strobe, irq;
	wire logic   timer_input_one, timer_input_two, internal_trigger_selection;
	wire logic [31:0] hrdata;
	wire logic [15:0] ch1_value_register;
	timer_channel1_capture_config dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .timer_input_one, .timer_input_two,
		.internal_trigger_selection, .dead_time_sample_clock(dts), .counter_value, .compare_reference,
		.protect_level, .ch1_main_output, .ch1_complement_output, .capture_strobe, .ch1_value_register, .irq);
	pin_source pins (.hclk, .go, .sel, .len(plen), .timer_input_one, .timer_input_two,
		.internal_trigger_selection);
	always #50 hclk = ~hclk;
	always @(posedge hclk) if (capture_strobe === 1'b1) scnt <= scnt + 1;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {26'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(r, exp);
	endtask
	// k pulses on source s; the counter shows v until after the latest rising capture, then ~v,
	// so a capture on the falling edge (polarity pairs 01 and 11) is told apart by its value
	task automatic cap(input logic [7:0] m, input logic [3:0] e, input logic [1:0] s, input logic [4:0] len,
			input int k, input int n, input logic [15:0] v);
		int c0;
		wr(6'h20, 32'h0);
		wr(6'h18, {24'h0, m});
		wr(6'h20, {28'h0, e});
		c0 = scnt;
		repeat (k) begin
			counter_value <= v;
			sel <= s;
			plen <= len;
			go <= 1'b1;
			@(posedge hclk);
			go <= 1'b0;
			repeat (13) @(posedge hclk);
			counter_value <= ~v;
			repeat (40) @(posedge hclk);
		end
		chk(32'(scnt - c0), 32'(n));
		if (n != 0) chk({16'h0, ch1_value_register}, {16'h0, e[1] ? ~v : v});
	endtask
	task automatic t_regs;
		rdc(6'h18, 32'h0);
		rdc(6'h20, 32'h0);
		rdc(6'h34, 32'h0);
		wr(6'h18, 32'hffff_ffff);
		rdc(6'h18, 32'h0000_00ff);
		wr(6'h20, 32'hffff_ffff);
		rdc(6'h20, 32'h0000_000f);
		wr(6'h18, 32'h0);
		rdc(6'h18, 32'h0000_0003);
		rdc(6'h04, 32'h0);
		wr(6'h20, 32'h0);
		wr(6'h18, 32'h0);
		rdc(6'h18, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_out;
		logic [3:0] e;
		for (int i = 0; i < 32; i++) begin
			e = i[3:0];
			wr(6'h20, {28'h0, e});
			compare_reference <= i[4];
			repeat (3) @(posedge hclk);
			chk({30'h0, ch1_main_output, ch1_complement_output}, {30'h0, e[0] & (i[4] ^ e[1]), e[2] & (~i[4] ^ e[3])});
		end
		protect_level <= 2'h2;
		wr(6'h20, 32'h0);
		rdc(6'h20, 32'h8);
		protect_level <= 2'h3;
		wr(6'h20, 32'h0);
		rdc(6'h20, 32'h8);
		protect_level <= 2'h0;
		wr(6'h20, 32'h0);
		rdc(6'h20, 32'h0);
		$display("test outputs done");
	endtask
	// rising-edge captures latch the value passed in
	task automatic t_dir;
		for (int d = 1; d < 4; d++) begin
			cap({6'h0, 2'(d)}, 4'h1, 2'(d - 1), 5'h0c, 1, 1, ~16'h1000);
			cap({6'h0, 2'(d)}, 4'h1, 2'(d % 3), 5'h0c, 1, 0, 16'h0);
		end
		cap(8'h01, 4'h0, 2'h0, 5'h0c, 1, 0, 16'h0);
		cap(8'h00, 4'h1, 2'h0, 5'h0c, 1, 0, 16'h0);
		$display("test direction done");
	endtask
	task automatic t_psc;
		for (int p = 0; p < 4; p++) begin
			cap({4'h0, 2'(p), 2'h1}, 4'h1, 2'h0, 5'h0c, 1 << p, 1, ~16'h2000);
			if (p != 0) cap({4'h0, 2'(p), 2'h1}, 4'h1, 2'h0, 5'h0c, (1 << p) - 1, 0, 16'h0);
		end
		$display("test prescaler done");
	endtask
	task automatic t_pol;
		cap(8'h01, 4'h3, 2'h0, 5'h0c, 1, 1, 16'hc33c);
		cap(8'h01, 4'hb, 2'h0, 5'h0c, 1, 2, 16'hc33c);
		$display("test polarity done");
	endtask
	task automatic t_filter;
		dts <= 1'b0;
		cap(8'h01, 4'h1, 2'h0, 5'h0c, 1, 0, 16'h0);
		dts <= 1'b1;
		cap(8'h11, 4'h1, 2'h0, 5'h01, 1, 0, 16'h0);
		cap(8'h11, 4'h1, 2'h0, 5'h0c, 1, 1, ~16'h4000);
		cap(8'h31, 4'h1, 2'h0, 5'h07, 1, 0, 16'h0);
		cap(8'h31, 4'h1, 2'h0, 5'h0c, 1, 1, 16'h4000);
		cap(8'h41, 4'h1, 2'h0, 5'h0a, 1, 0, 16'h0);
		cap(8'h41, 4'h1, 2'h0, 5'h14, 1, 1, 16'h4000);
		$display("test filter done");
	endtask
	task automatic t_irq;
		wr(6'h38, 32'h3);
		wr(6'h3c, 32'h1);
		rdc(6'h3c, 32'h1);
		chk({31'h0, irq}, 32'h0);
		cap(8'h01, 4'h1, 2'h0, 5'h0c, 1, 1, 16'h0042);
		chk({31'h0, irq}, 32'h1);
		rdc(6'h38, 32'h1);
		rdc(6'h34, 32'h42);
		wr(6'h38, 32'h1);
		repeat (2) @(posedge hclk);
		chk({31'h0, irq}, 32'h0);
		wr(6'h3c, 32'h0);
		cap(8'h01, 4'h1, 2'h0, 5'h0c, 1, 1, 16'h0043);
		chk({31'h0, irq}, 32'h0);
		rdc(6'h38, 32'h1);
		$display("test interrupt done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_out();
		t_dir();
		t_psc();
		t_pol();
		t_filter();
		t_irq();
		results();
	end
	// about 2800 cycles are expected; the limit leaves wide margin
	initial begin
		#1_000_000;
		error_cnt++;
		results();
	end
endmodule
`default_nettype wire
